// [bms_boot_mode_select.sv]
`timescale 1ns/1ps
module bms_boot_mode_select
(
    input  wire logic             clk,               // 40 MHz CPU clock
    input  wire logic             rst,               // reset_input_pin level
    input  wire logic             bootSelectLowPin,  // Boot pin, low
    input  wire logic             bootSelectHighPin, // Boot pin, high
    input  wire logic             uartReceiveLine,   // UART RX pin
    input  wire logic             canReceiveLine,    // CAN RX pin
    input  wire logic             userSigOk,         // User signature good
    input  wire logic             altSigOk,          // Alt signature good
    input  wire logic             keyReadValid,      // Key data returned
    input  wire logic [15:0]      keyReadData,       // User key value
    output bms_pkg::bms_cfg_t     bootCfg,           // Memory map setup
    output bms_pkg::bms_chan_t    chanSel,           // Loader channel
    output logic [23:0]           startAddr,         // Execution start
    output logic                  startValid,        // Start address final
    output logic                  softResetReq,      // One-cycle pulse
    output logic                  keyReadReq,        // One-cycle pulse
    output logic [15:0]           loaderKey          // Key steering loader
);

    //==========================================================
    // Pin synchronisers
    //==========================================================
    logic [3:0]               pinRaw;
    logic                     pinLvl_q  [4]; // One element per loop
    logic [2:0]               pinSync_q [4]; // Unpacked: one writer each
    logic                     uartPrev_q;
    logic                     canPrev_q;

    assign pinRaw = {canReceiveLine, uartReceiveLine,
                     bootSelectHighPin, bootSelectLowPin};

    // Level moves only when stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    pinSync_q[gi] <= {3{bms_pkg::LINE_IDLE}};
                    pinLvl_q[gi]  <= bms_pkg::LINE_IDLE;
                end
                else
                begin
                    pinSync_q[gi] <= {pinSync_q[gi][1:0], pinRaw[gi]};
                    if (pinSync_q[gi][1] == pinSync_q[gi][2])
                        pinLvl_q[gi] <= pinSync_q[gi][2];
                end
            end
        end
    endgenerate

    logic uartLvl;
    logic canLvl;
    logic uartStart;
    logic canFall;
    logic canRise;

    assign uartLvl   = pinLvl_q[2];
    assign canLvl    = pinLvl_q[3];
    assign uartStart = uartPrev_q & ~uartLvl;
    assign canFall   = canPrev_q & ~canLvl;
    assign canRise   = ~canPrev_q & canLvl;

    // Previous levels for edge detection
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            uartPrev_q <= bms_pkg::LINE_IDLE;
            canPrev_q  <= bms_pkg::LINE_IDLE;
        end
        else
        begin
            uartPrev_q <= uartLvl;
            canPrev_q  <= canLvl;
        end
    end

    //==========================================================
    // Glitch filter on CAN receive line
    //==========================================================
    logic [4:0] canLowCnt_q;
    logic       canDominant;
    logic       canWindow_q;

    // Saturating run length of a low CAN line
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            canLowCnt_q <= 5'h00;
        else if (canLvl)
            canLowCnt_q <= 5'h00;
        else if (canLowCnt_q != 5'(bms_pkg::CAN_FILTER_CYCLES))
            canLowCnt_q <= canLowCnt_q + 5'h01;
    end

    // Short pulses never reach the count
    assign canDominant = ~canLvl &&
        (canLowCnt_q == 5'(bms_pkg::CAN_FILTER_CYCLES - 1));

    // Window from CAN fall to next rise; UART must win inside it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            canWindow_q <= 1'b0;
        else if (canFall)
            canWindow_q <= 1'b1;
        else if (canRise)
            canWindow_q <= 1'b0;
    end

    //==========================================================
    // Boot sequencer
    //==========================================================
    bms_pkg::bms_state_t state_q;
    logic [2:0]          fillCnt_q;
    logic [1:0]          capPins_q;

    // Pins are caught once the chain holds reset-time values;
    // the chain restarts with each reset so the mode is fresh.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q      <= bms_pkg::ST_WAIT;
            fillCnt_q    <= 3'h0;
            capPins_q    <= bms_pkg::PINS_USER;
            bootCfg      <= '0;
            chanSel      <= '0;
            startAddr    <= bms_pkg::USER_START_ADDR;
            startValid   <= 1'b0;
            softResetReq <= 1'b0;
            keyReadReq   <= 1'b0;
            loaderKey    <= 16'h0000;
        end
        else
        begin
            softResetReq <= 1'b0;
            keyReadReq   <= 1'b0;
            case (state_q)
                bms_pkg::ST_WAIT:
                begin
                    fillCnt_q <= fillCnt_q + 3'h1;
                    if (fillCnt_q == 3'(bms_pkg::SYNC_FILL_CYCLES))
                    begin
                        capPins_q <= {pinLvl_q[1], pinLvl_q[0]};
                        state_q   <= bms_pkg::ST_DECODE;
                    end
                end
                bms_pkg::ST_DECODE:
                begin
                    bootCfg.modeReserved <=
                        (capPins_q == bms_pkg::PINS_RESERVED);
                    bootCfg.userFlashActive <= 1'b1;
                    if (!capPins_q[0])
                    begin
                        // Serial boot regardless of bus mode
                        bootCfg.serialBoot    <= 1'b1;
                        bootCfg.fetchRedirect <= 1'b1;
                        startAddr <= bms_pkg::BOOT_ENTRY_ADDR;
                        state_q   <= bms_pkg::ST_SCAN;
                    end
                    else if (capPins_q[1])
                    begin
                        startAddr  <= bms_pkg::USER_START_ADDR;
                        startValid <= 1'b1;
                        state_q    <= bms_pkg::ST_DONE;
                    end
                    else
                        state_q <= bms_pkg::ST_SIGCHK;
                end
                bms_pkg::ST_SIGCHK:
                begin
                    if (userSigOk)
                    begin
                        softResetReq <= 1'b1;
                        startAddr    <= bms_pkg::USER_START_ADDR;
                        startValid   <= 1'b1;
                        state_q      <= bms_pkg::ST_DONE;
                    end
                    else if (altSigOk)
                    begin
                        startAddr  <= bms_pkg::ALT_START_ADDR;
                        startValid <= 1'b1;
                        state_q    <= bms_pkg::ST_DONE;
                    end
                    else
                    begin
                        keyReadReq <= 1'b1;
                        state_q    <= bms_pkg::ST_KEYRD;
                    end
                end
                bms_pkg::ST_KEYRD:
                begin
                    if (keyReadValid)
                    begin
                        loaderKey             <= keyReadData;
                        bootCfg.serialBoot    <= 1'b1;
                        bootCfg.fetchRedirect <= 1'b1;
                        startAddr <= bms_pkg::BOOT_ENTRY_ADDR;
                        state_q   <= bms_pkg::ST_SCAN;
                    end
                end
                bms_pkg::ST_SCAN:
                begin
                    // UART is checked first so it wins a tie
                    if (uartStart)
                    begin
                        chanSel.uartSelected <= 1'b1;
                        startValid <= 1'b1;
                        state_q    <= bms_pkg::ST_DONE;
                    end
                    else if (canDominant)
                    begin
                        chanSel.canSelected <= 1'b1;
                        startValid <= 1'b1;
                        state_q    <= bms_pkg::ST_DONE;
                    end
                end
                bms_pkg::ST_DONE:
                    state_q <= bms_pkg::ST_DONE;
                default:
                    state_q <= bms_pkg::ST_WAIT;
            endcase
        end
    end

    //==========================================================
    // Checks
    //==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence seqCapture;
        state_q == bms_pkg::ST_WAIT &&
            fillCnt_q == 3'(bms_pkg::SYNC_FILL_CYCLES);
    endsequence

    sequence seqSigEntry;
        state_q == bms_pkg::ST_SIGCHK;
    endsequence

    a_pin_capture: assert property
        (seqCapture |=> capPins_q == $past({pinLvl_q[1], pinLvl_q[0]}))
        else $error("boot pins not captured");
    a_user_map: assert property
        (state_q == bms_pkg::ST_DECODE && capPins_q == bms_pkg::PINS_USER
         |=> startValid && startAddr == 24'h00_0000 && !bootCfg.serialBoot)
        else $error("user mode map wrong");
    a_std_redirect: assert property
        (state_q == bms_pkg::ST_DECODE &&
         capPins_q == bms_pkg::PINS_STD_SERIAL
         |=> bootCfg.fetchRedirect && bootCfg.userFlashActive)
        else $error("standard boot map wrong");
    a_sig_user: assert property
        (seqSigEntry ##0 userSigOk |=> softResetReq ##1 !softResetReq)
        else $error("user signature reset missing");
    a_sig_alt: assert property
        (seqSigEntry ##0 (!userSigOk && altSigOk)
         |=> startAddr == 24'h09_0000 && !softResetReq)
        else $error("alternate start wrong");
    a_key_read: assert property
        (seqSigEntry ##0 (!userSigOk && !altSigOk)
         |=> keyReadReq && state_q == bms_pkg::ST_KEYRD)
        else $error("key reread missing");
    a_selective: assert property
        (state_q == bms_pkg::ST_KEYRD && keyReadValid
         |=> state_q == bms_pkg::ST_SCAN && loaderKey == $past(keyReadData))
        else $error("selective boot entry wrong");
    a_serial_entry: assert property
        (state_q == bms_pkg::ST_DECODE && !capPins_q[0]
         |=> bootCfg.serialBoot && state_q == bms_pkg::ST_SCAN)
        else $error("serial boot not entered");
    a_uart_first: assert property
        (state_q == bms_pkg::ST_SCAN && uartStart
         |=> chanSel == 2'h2)
        else $error("uart not selected");
    a_can_first: assert property
        (state_q == bms_pkg::ST_SCAN && canDominant && !uartStart
         |=> chanSel == 2'h1)
        else $error("can not selected");
    a_uart_window: assert property
        (state_q == bms_pkg::ST_SCAN && canWindow_q && uartStart
         |=> chanSel.uartSelected && !chanSel.canSelected)
        else $error("uart lost priority in can window");
    a_can_filter: assert property
        (canDominant |-> $past(canLvl, 19) == 1'b0 && !canLvl)
        else $error("short can pulse accepted");
    a_mode_hold: assert property
        (state_q != bms_pkg::ST_WAIT |=> $stable(capPins_q))
        else $error("captured mode changed");

endmodule : bms_boot_mode_select

// [bms_host_model.sv]
`timescale 1ns/1ps
//==============================================================
// Board strap pins and signature and key store
//==============================================================
module bms_host_model
(
    input  wire logic        clk,               // CPU clock
    input  wire logic        rst,               // Reset level
    input  wire logic [1:0]  cfgPins,           // Wanted {high, low}
    input  wire logic        userOk,            // Wanted user signature
    input  wire logic        altOk,             // Wanted alt signature
    input  wire logic [15:0] keyValue,          // Key to hand back
    input  wire logic [3:0]  keyDelay,          // Key answer latency
    input  wire logic        keyReadReq,        // Key reread request
    output logic             bootSelectLowPin,  // Strap pin low
    output logic             bootSelectHighPin, // Strap pin high
    output logic             userSigOk,         // User signature state
    output logic             altSigOk,          // Alt signature state
    output logic             keyReadValid,      // Key strobe
    output logic [15:0]      keyReadData        // Key bus
);
    logic [3:0]  holdCnt_q; // Cycles since release
    logic [3:0]  keyCnt_q;  // Key answer countdown
    logic        keyPend_q; // Request outstanding
    logic [15:0] junk_q;    // Idle bus pattern

    // Signature state is static flash content
    assign userSigOk = userOk;
    assign altSigOk  = altOk;

    // Straps held through reset and past capture, then they flip to the inverse and stay
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            holdCnt_q <= 4'h0;
            {bootSelectHighPin, bootSelectLowPin} <= cfgPins;
        end
        else if (holdCnt_q != 4'hF)
        begin
            holdCnt_q <= holdCnt_q + 4'h1;
            if (holdCnt_q == 4'h8)
            begin
                {bootSelectHighPin, bootSelectLowPin} <= ~cfgPins;
            end
        end
    end

    // Key answer; bus shows a moving pattern when not valid
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            keyPend_q    <= 1'b0;
            keyCnt_q     <= 4'h0;
            keyReadValid <= 1'b0;
            junk_q       <= 16'hA5C3;
            keyReadData  <= 16'h5A3C;
        end
        else
        begin
            junk_q       <= junk_q + 16'h1357;
            keyReadValid <= 1'b0;
            keyReadData  <= junk_q;
            if (keyReadReq)
            begin
                keyPend_q <= 1'b1;
                keyCnt_q  <= keyDelay;
            end
            else if (keyPend_q && keyCnt_q != 4'h0)
            begin
                keyCnt_q <= keyCnt_q - 4'h1;
            end
            else if (keyPend_q)
            begin
                keyPend_q    <= 1'b0;
                keyReadValid <= 1'b1;
                keyReadData  <= keyValue;
            end
        end
    end
endmodule : bms_host_model

// [bms_pkg.sv]
//==============================================================
// Boot mode selection constants and types
//==============================================================
package bms_pkg;

    //==========================================================
    // Timing and addresses
    //==========================================================
    localparam int unsigned   SYNC_FILL_CYCLES  = 5;  // Sync chain settles
    localparam int unsigned   CAN_FILTER_CYCLES = 20; // Least dominant width
    localparam logic [23:0]   USER_START_ADDR   = 24'h00_0000;
    localparam logic [23:0]   ALT_START_ADDR    = 24'h09_0000;
    localparam logic [23:0]   BOOT_ENTRY_ADDR   = 24'h00_0000;
    localparam logic          LINE_IDLE         = 1'h1;

    // Captured pins as {high, low}
    localparam logic [1:0]    PINS_USER         = 2'h3;
    localparam logic [1:0]    PINS_STD_SERIAL   = 2'h2;
    localparam logic [1:0]    PINS_SIG_CHECK    = 2'h1;
    localparam logic [1:0]    PINS_RESERVED     = 2'h0;

    //==========================================================
    // Types
    //==========================================================
    typedef enum logic [2:0]
    {
        ST_WAIT   = 3'h0,
        ST_DECODE = 3'h1,
        ST_SIGCHK = 3'h3,
        ST_KEYRD  = 3'h2,
        ST_SCAN   = 3'h6,
        ST_DONE   = 3'h7
    } bms_state_t;

    typedef struct packed
    {
        logic modeReserved;    // Reserved pin code captured
        logic serialBoot;      // serial_boot_mode active
        logic fetchRedirect;   // Code fetch at zero from boot flash
        logic userFlashActive; // User flash open for read/program
    } bms_cfg_t;

    typedef struct packed
    {
        logic uartSelected;    // UART loading chosen
        logic canSelected;     // CAN loading chosen
    } bms_chan_t;

endpackage : bms_pkg

// [boot_mode_select_tb.sv]
`timescale 1ns/1ps
//==============================================================
// Boot mode selection testbench
//==============================================================
module boot_mode_select_tb;
    logic               clk, rst, userOk, altOk, uartLine, canLine;
    logic [1:0]         cfgPins;
    logic [15:0]        keyValue, kv, loaderKey, keyReadData;
    logic [3:0]         keyDelay;
    logic               lowPin, highPin, userSigOk, altSigOk;
    logic               keyReadValid, keyReadReq;
    logic               startValid, softResetReq, svPrev;
    bms_pkg::bms_cfg_t  bootCfg;
    bms_pkg::bms_chan_t chanSel;
    logic [23:0]        startAddr;
    logic [46:0]        cur, curExp, curMask;
    logic [46:0]        expQ[$];
    logic [46:0]        maskQ[$];
    int                 nFail, numChecks, nDone, holdCnt, seed;
    int                 nKeyReq;

    assign cur = {bootCfg, chanSel, startAddr, softResetReq, loaderKey};

    bms_host_model bms_host_model_i (.clk(clk), .rst(rst),
        .cfgPins(cfgPins), .userOk(userOk), .altOk(altOk),
        .keyValue(keyValue), .keyDelay(keyDelay), .keyReadReq(keyReadReq),
        .bootSelectLowPin(lowPin), .bootSelectHighPin(highPin),
        .userSigOk(userSigOk), .altSigOk(altSigOk),
        .keyReadValid(keyReadValid), .keyReadData(keyReadData));

    bms_boot_mode_select bms_boot_mode_select_i (.clk(clk), .rst(rst),
        .bootSelectLowPin(lowPin), .bootSelectHighPin(highPin),
        .uartReceiveLine(uartLine), .canReceiveLine(canLine),
        .userSigOk(userSigOk), .altSigOk(altSigOk),
        .keyReadValid(keyReadValid), .keyReadData(keyReadData),
        .bootCfg(bootCfg), .chanSel(chanSel), .startAddr(startAddr),
        .startValid(startValid), .softResetReq(softResetReq),
        .keyReadReq(keyReadReq), .loaderKey(loaderKey));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Result vector: cfg, channel, address, soft reset, key
    function automatic logic [46:0] mk(input logic [3:0] c,
        input logic [1:0] ch, input logic [23:0] a, input logic s,
        input logic [15:0] k);
        return {c, ch, a, s, k};
    endfunction : mk

    // Masked compare, unknowns never match
    task automatic check(input logic [46:0] got, input logic [46:0] e,
        input logic [46:0] m);
        numChecks++;
        if (((got ^ e) & m) !== 47'h0)
        begin
            nFail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got & m, e & m);
        end
    endtask : check

    task automatic endSim();
        $display("checks=%0d failures=%0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : endSim

    // Watcher: oldest note against each start event, again 29 later
    always @(negedge clk)
    begin
        if (rst)
        begin
            svPrev  = 1'b0;
            holdCnt = 0;
            nKeyReq = 0;
        end
        else
        begin
            // Key reread pulses since reset
            if (keyReadReq === 1'b1)
                nKeyReq++;
            if (startValid === 1'b1 && !svPrev)
            begin
                if (expQ.size() == 0)
                begin
                    nFail++;
                    $display("ERROR t=%0t got=%h exp=%h", $time, cur, 0);
                end
                else
                begin
                    curExp  = expQ.pop_front();
                    curMask = maskQ.pop_front();
                    check(cur, curExp, curMask);
                    holdCnt = 30;
                end
            end
            else if (holdCnt == 1)
            begin
                // Pins have moved, lines too after a serial boot; pulse bit left out
                check(cur, curExp, curMask & ~(47'h1 << 16));
                nDone++;
            end
            if (holdCnt > 0)
                holdCnt--;
            svPrev = (startValid === 1'b1);
        end
    end

    // One boot: reset with straps, then line activity
    task automatic run(input logic [1:0] pins, input logic uok,
        input logic aok, input int act, input logic [46:0] e,
        input logic [46:0] m);
        int i;
        int target;
        target = nDone + 1;
        expQ.push_back(e);
        maskQ.push_back(m);
        @(posedge clk);
        rst <= 1'b1;
        cfgPins <= pins;
        userOk <= uok;
        altOk <= aok;
        repeat (16) @(posedge clk);
        @(negedge clk);
        check(cur, 47'h0, {47{1'b1}});
        @(posedge clk) rst <= 1'b0;
        repeat (40) @(posedge clk);
        if (act == 1 || act == 4)
            canLine <= 1'b0;
        if (act == 1)
            repeat (19) @(posedge clk);
        if (act == 1)
            canLine <= 1'b1;
        repeat (5) @(posedge clk);
        if (act != 2)
            uartLine <= 1'b0;
        if (act == 2)
            canLine <= 1'b0;
        repeat (30) @(posedge clk);
        uartLine <= 1'b1;
        canLine <= 1'b1;
        for (i = 0; i < 400 && nDone < target; i++)
            @(posedge clk);
        // Exactly one reread, and only with both signatures bad
        check(47'(nKeyReq), 47'(pins == 2'h1 && !uok && !aok), '1);
        if (nDone < target)
        begin
            nFail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, nDone, target);
            endSim();
        end
    endtask : run

    // Main sequence
    initial
    begin
        seed = 53;
        rst = 1'b1;
        cfgPins = 2'h3;
        userOk = 1'b0;
        altOk = 1'b0;
        uartLine = 1'b1;
        canLine = 1'b1;
        keyValue = 16'h0000;
        keyDelay = 4'h0;
        nFail = 0;
        numChecks = 0;
        nDone = 0;
        run(2'h3, 1'b0, 1'b0, 0,
            mk(4'h1, 2'h0, bms_pkg::USER_START_ADDR, 1'b0, 16'h0), '1);
        run(2'h2, 1'b0, 1'b0, 0,
            mk(4'h7, 2'h2, bms_pkg::BOOT_ENTRY_ADDR, 1'b0, 16'h0), '1);
        run(2'h0, 1'b0, 1'b0, 2,
            mk(4'hC, 2'h1, bms_pkg::BOOT_ENTRY_ADDR, 1'b0, 16'h0),
            mk(4'hC, 2'h3, 24'hFFFFFF, 1'b1, 16'hFFFF));
        run(2'h2, 1'b0, 1'b0, 1,
            mk(4'h7, 2'h2, bms_pkg::BOOT_ENTRY_ADDR, 1'b0, 16'h0), '1);
        run(2'h2, 1'b0, 1'b1, 4,
            mk(4'h7, 2'h2, bms_pkg::BOOT_ENTRY_ADDR, 1'b0, 16'h0), '1);
        run(2'h1, 1'b1, 1'b1, 0,
            mk(4'h0, 2'h0, bms_pkg::USER_START_ADDR, 1'b1, 16'h0),
            mk(4'hE, 2'h3, 24'hFFFFFF, 1'b1, 16'hFFFF));
        run(2'h1, 1'b0, 1'b1, 0,
            mk(4'h0, 2'h0, bms_pkg::ALT_START_ADDR, 1'b0, 16'h0),
            mk(4'hE, 2'h3, 24'hFFFFFF, 1'b1, 16'hFFFF));
        kv = 16'($random(seed));
        @(posedge clk);
        keyValue <= kv;
        keyDelay <= 4'($random(seed));
        run(2'h1, 1'b0, 1'b0, 2,
            mk(4'h6, 2'h1, bms_pkg::BOOT_ENTRY_ADDR, 1'b0, kv),
            mk(4'hE, 2'h3, 24'hFFFFFF, 1'b1, 16'hFFFF));
        endSim();
    end
endmodule : boot_mode_select_tb
